// ### verilog/ldio_regs.svh
// Purpose: Index, reset and range constants for the logical device I/O decode block
// Assumes: Included by bare name; holds definitions only
// Notes:   Config port limits are 16-bit, other base constants 12-bit I/O addresses; alignments are given as low zero bits
`ifndef LDIO_REGS_SVH
`define LDIO_REGS_SVH

// Configuration register indices
`define LDIO_IDX_LDN        8'h07
`define LDIO_IDX_PWR_LO     8'h22
`define LDIO_IDX_PWR_HI     8'h23
`define LDIO_IDX_OSC        8'h24
`define LDIO_IDX_CPORT_LO   8'h26
`define LDIO_IDX_CPORT_HI   8'h27
`define LDIO_IDX_ACT        8'h30
`define LDIO_IDX_BASE0_HI   8'h60
`define LDIO_IDX_BASE0_LO   8'h61
`define LDIO_IDX_BASE1_HI   8'h62
`define LDIO_IDX_BASE1_LO   8'h63
`define LDIO_IDX_IRQ        8'h70
`define LDIO_IDX_DMA        8'h74

// Field positions
`define LDIO_OSC_QUAL16_BIT 6
`define LDIO_ACT_BIT        0

// Reset values
`define LDIO_CPORT_STRAP0   16'h002E
`define LDIO_CPORT_STRAP1   16'h004E
`define LDIO_IRQ_RST_LDN0   4'h6
`define LDIO_IRQ_RST_OTHER  4'h0
`define LDIO_DMA_RST_LDN0   3'h2
`define LDIO_DMA_RST_PP_SP  3'h4
`define LDIO_DMA_RST_OTHER  3'h0

// Logical device numbers
`define LDIO_LDN_FDC        4'h0
`define LDIO_LDN_PP         4'h3
`define LDIO_LDN_SP1        4'h4
`define LDIO_LDN_SP2        4'h5
`define LDIO_LDN_KBD        4'h7
`define LDIO_LDN_GAME       4'h9
`define LDIO_LDN_RT         4'hA
`define LDIO_LDN_MPU        4'hB

// Base ranges, fixed addresses and the shared management interrupt line
`define LDIO_CPORT_MIN      16'h0100
`define LDIO_CPORT_MAX      16'h0FFE
`define LDIO_KBD_DATA       12'h060
`define LDIO_KBD_CMD        12'h064
`define LDIO_ECP_OFS        12'h400
`define LDIO_SMI_IRQ        4'h2

`endif

// ### verilog/ldio_pkg.sv
// Purpose: Shared types of the logical device I/O decode block
// Assumes: Used with ldio_regs.svh for all numeric constants
// Notes:   Nothing here is imported; users write ldio_pkg::name
`default_nettype none

package ldio_pkg;

  // One host I/O cycle, valid for a single clock
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ldio_host_req_s;

  // Registered select toward the logical devices
  typedef struct packed {
    logic [11:0] sel;
    logic [11:0] ofs;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } ldio_dev_sel_s;

  typedef logic [11:0] ldio_io12_t;

endpackage

`default_nettype wire

// ### verilog/ldio_window.sv
// Purpose: Match one host address against one relocatable device window
// Assumes: Base and address on the same clock; output is combinational
// Notes:   A base outside its range or off its alignment never matches
`default_nettype none

module ldio_window #(
  parameter logic [11:0] MIN_BASE  = 12'h100,
  parameter logic [11:0] MAX_BASE  = 12'hFF8,
  parameter int          ALIGN     = 3,
  parameter int          SPAN      = 3,
  parameter logic [7:0]  OFS_MASK  = 8'hFF,
  parameter logic [11:0] OFS_BASE  = 12'h000
) (
  input  wire logic [15:0] base,
  input  wire logic        active,
  input  wire logic        qual16,
  input  wire logic [15:0] addr,
  output logic             hit,
  output logic [11:0]      ofs
);

  logic [11:0] diff;
  logic        base_ok;
  logic        ofs_ok;

  initial begin
    if (ALIGN < 0 || ALIGN > 11 || SPAN < 0 || SPAN > 11)
      $error("ldio_window: ALIGN and SPAN must lie in 0..11");
  end

  // Base must sit in range and on its boundary
  always_comb begin
    base_ok = (base[15:12] == 4'h0) && (base[11:0] >= MIN_BASE) && (base[11:0] <= MAX_BASE);
    if (ALIGN > 0)
      base_ok = base_ok && ((base[11:0] & ~(12'hFFF << ALIGN)) == 12'h000);
  end

  // Only A11..A0 take part unless full qualification is on
  assign diff   = addr[11:0] - base[11:0] - OFS_BASE;
  assign ofs    = diff + OFS_BASE;
  assign ofs_ok = (SPAN > 3) ? 1'b1 : OFS_MASK[diff[2:0]];
  assign hit    = active && base_ok && ofs_ok && ((diff >> SPAN) == 12'h000)
                  && (!qual16 || addr[15:12] == 4'h0);

endmodule

`default_nettype wire

// ### verilog/ldio_decode.sv
// Purpose: Configuration port, banked device registers and I/O select decode
// Assumes: Host cycles arrive as one-cycle strobes on clk; rst covers all resets
// Notes:   Device selects and config read data appear one clock after the strobe
`include "ldio_regs.svh"
`default_nettype none

module ldio_decode #(
  parameter int NUM_LDN = 12
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ldio_pkg::ldio_host_req_s host_req,
  input  wire logic                   config_port_strap,
  input  wire logic [11:0]            dev_irq_req,
  input  wire logic                   pp_ecp_epp_mode,
  input  wire logic                   smi_req,
  output ldio_pkg::ldio_dev_sel_s     dev_sel,
  output logic [7:0]                  cfg_rdata,
  output logic                        cfg_rvalid,
  output logic [15:0]                 irq_lines,
  output logic                        sys_mgmt_irq_n,
  output logic [15:0]                 cfg_port_addr,
  output logic [11:0]                 dev_on
);

  initial begin
    if (NUM_LDN != 12)
      $error("ldio_decode: NUM_LDN must be 12");
  end

  // Configuration state
  logic [7:0]  index_r;
  logic [3:0]  ldn_r;
  logic [7:0]  osc_r;
  logic [15:0] cport_r;
  logic [7:0]  cport_lo_r;
  logic [7:0]  cport_hi_r;
  logic        strap_done_r;
  logic [2:0]  strap_sync_r;
  logic [1:0]  strap_fill_r;

  // Banked per-device state
  logic [11:0] act_r;
  logic [11:0] pwr_r;
  logic [15:0] base_r [NUM_LDN];
  logic [3:0]  irq_r  [NUM_LDN];
  logic [2:0]  dma_r  [NUM_LDN];

  // Output registers
  ldio_pkg::ldio_dev_sel_s dev_sel_r;
  logic [7:0]  cfg_rdata_r;
  logic        cfg_rvalid_r;
  logic [15:0] irq_lines_r;
  logic        smi_n_r;

  // Decode nets
  logic        qual16;
  logic        cport_hit;
  logic        idx_hit;
  logic        dat_hit;
  logic        dat_wr;
  logic [11:0] on_vec;
  logic [11:0] hit_vec;
  logic [11:0] sel_nxt;
  logic [11:0] ofs_nxt;
  logic [11:0] ofs_fdc;
  logic [11:0] ofs_pp;
  logic [11:0] ofs_epp;
  logic [11:0] ofs_ecp;
  logic [11:0] ofs_sp1;
  logic [11:0] ofs_sp2;
  logic [11:0] ofs_game;
  logic [11:0] ofs_rt;
  logic [11:0] ofs_mpu;
  logic        hit_pp;
  logic        hit_epp;
  logic        hit_ecp;
  logic        hit_kbd;
  logic [15:0] cport_cand;
  logic [7:0]  rdata_nxt;
  logic [15:0] irq_nxt;
  logic        smi_share;

  assign qual16 = osc_r[`LDIO_OSC_QUAL16_BIT];
  assign on_vec = act_r | pwr_r;

  // Config port decode: index at the port, data one above
  assign cport_hit = strap_done_r && (!qual16 || host_req.addr[15:12] == 4'h0);
  assign idx_hit   = cport_hit && (host_req.addr == cport_r);
  assign dat_hit   = cport_hit && (host_req.addr == cport_r + 16'h0001);
  assign dat_wr    = dat_hit && host_req.wr;

  // Strap input passes three flops; first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_sync_r <= 3'b000;
      strap_fill_r <= 2'h0;
    end else begin
      strap_sync_r <= {strap_sync_r[1:0], config_port_strap};
      if (strap_fill_r != 2'h3)
        strap_fill_r <= strap_fill_r + 2'h1;                   // Stages hold reset zeros until full
    end
  end

  // Config port address: strap after reset, then software relocation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cport_r      <= `LDIO_CPORT_STRAP0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_fill_r == 2'h3 && strap_sync_r[1] == strap_sync_r[2]) begin
        cport_r      <= strap_sync_r[2] ? `LDIO_CPORT_STRAP1 : `LDIO_CPORT_STRAP0;
        strap_done_r <= 1'b1;
      end
    end else if (dat_wr && (index_r == `LDIO_IDX_CPORT_LO || index_r == `LDIO_IDX_CPORT_HI)) begin
      if (cport_cand >= `LDIO_CPORT_MIN && cport_cand <= `LDIO_CPORT_MAX
          && !cport_cand[0])
        cport_r <= cport_cand;
    end
  end

  // Candidate port formed from the byte being written and the held byte
  always_comb begin
    cport_cand = {cport_hi_r, cport_lo_r};
    if (index_r == `LDIO_IDX_CPORT_LO)
      cport_cand = {cport_hi_r, host_req.wdata};
    else if (index_r == `LDIO_IDX_CPORT_HI)
      cport_cand = {host_req.wdata, cport_lo_r};
  end

  // Held bytes of the relocation pair
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cport_lo_r <= 8'h00;
      cport_hi_r <= 8'h00;
    end else if (dat_wr && index_r == `LDIO_IDX_CPORT_LO) begin
      cport_lo_r <= host_req.wdata;
    end else if (dat_wr && index_r == `LDIO_IDX_CPORT_HI) begin
      cport_hi_r <= host_req.wdata;
    end
  end

  // Index latch and global registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_r <= 8'h00;
      ldn_r   <= 4'h0;
      osc_r   <= 8'h00;
    end else begin
      if (idx_hit && host_req.wr)
        index_r <= host_req.wdata;
      if (dat_wr && index_r == `LDIO_IDX_LDN)
        ldn_r <= host_req.wdata[3:0];
      if (dat_wr && index_r == `LDIO_IDX_OSC)
        osc_r <= host_req.wdata;
    end
  end

  // Activate and power bits: a write to either sets both
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_r <= 12'h000;
      pwr_r <= 12'h000;
    end else if (dat_wr) begin
      if (index_r == `LDIO_IDX_ACT && ldn_r < NUM_LDN) begin
        act_r[ldn_r] <= host_req.wdata[`LDIO_ACT_BIT];
        pwr_r[ldn_r] <= host_req.wdata[`LDIO_ACT_BIT];
      end else if (index_r == `LDIO_IDX_PWR_LO) begin
        act_r[7:0] <= host_req.wdata;
        pwr_r[7:0] <= host_req.wdata;
      end else if (index_r == `LDIO_IDX_PWR_HI) begin
        act_r[11:8] <= host_req.wdata[3:0];
        pwr_r[11:8] <= host_req.wdata[3:0];
      end
    end
  end

  // Banked base, interrupt and DMA selects with their reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LDN; i++) begin
        base_r[i] <= 16'h0000;
        irq_r[i]  <= (i == 0) ? `LDIO_IRQ_RST_LDN0 : `LDIO_IRQ_RST_OTHER;
        dma_r[i]  <= (i == 0) ? `LDIO_DMA_RST_LDN0 :
                     (i == 3 || i == 5) ? `LDIO_DMA_RST_PP_SP : `LDIO_DMA_RST_OTHER;
      end
    end else if (dat_wr && ldn_r < NUM_LDN) begin
      unique case (index_r)
        `LDIO_IDX_BASE0_HI: base_r[ldn_r][15:8] <= host_req.wdata;
        `LDIO_IDX_BASE0_LO: base_r[ldn_r][7:0]  <= host_req.wdata;
        `LDIO_IDX_IRQ:      irq_r[ldn_r]        <= host_req.wdata[3:0];
        `LDIO_IDX_DMA:      dma_r[ldn_r]        <= host_req.wdata[2:0];
        default: ;
      endcase
    end
  end

  // Config read mux; unused and reserved indices read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (idx_hit) begin
      rdata_nxt = index_r;
    end else if (ldn_r < NUM_LDN) begin
      unique case (index_r)
        `LDIO_IDX_LDN:      rdata_nxt = {4'h0, ldn_r};
        `LDIO_IDX_PWR_LO:   rdata_nxt = pwr_r[7:0];
        `LDIO_IDX_PWR_HI:   rdata_nxt = {4'h0, pwr_r[11:8]};
        `LDIO_IDX_OSC:      rdata_nxt = osc_r;
        `LDIO_IDX_CPORT_LO: rdata_nxt = cport_r[7:0];
        `LDIO_IDX_CPORT_HI: rdata_nxt = cport_r[15:8];
        `LDIO_IDX_ACT:      rdata_nxt = {7'h00, act_r[ldn_r]};
        `LDIO_IDX_BASE0_HI: rdata_nxt = base_r[ldn_r][15:8];
        `LDIO_IDX_BASE0_LO: rdata_nxt = base_r[ldn_r][7:0];
        `LDIO_IDX_IRQ:      rdata_nxt = {4'h0, irq_r[ldn_r]};
        `LDIO_IDX_DMA:      rdata_nxt = {5'h00, dma_r[ldn_r]};
        default:            rdata_nxt = 8'h00;
      endcase
    end
  end

  // Config read answer one clock after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_r  <= 8'h00;
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rvalid_r <= host_req.rd && (idx_hit || dat_hit);
      if (host_req.rd && (idx_hit || dat_hit))
        cfg_rdata_r <= rdata_nxt;
    end
  end

  // Floppy: 8-byte aligned, offsets 0..5 and 7
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFF8), .ALIGN(3), .SPAN(3),
                .OFS_MASK(8'hBF), .OFS_BASE(12'h000)) u_fdc (
    .base(base_r[0]), .active(on_vec[0]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_vec[0]), .ofs(ofs_fdc));

  // Parallel standard registers on 4-byte alignment
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFFC), .ALIGN(2), .SPAN(3),
                .OFS_MASK(8'h07), .OFS_BASE(12'h000)) u_pp (
    .base(base_r[3]), .active(on_vec[3]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_pp), .ofs(ofs_pp));

  // EPP registers only when the base is 8-byte aligned
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFF8), .ALIGN(3), .SPAN(3),
                .OFS_MASK(8'hF8), .OFS_BASE(12'h000)) u_epp (
    .base(base_r[3]), .active(on_vec[3]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_epp), .ofs(ofs_epp));

  // ECP registers at base plus 400h..402h
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFFC), .ALIGN(2), .SPAN(3),
                .OFS_MASK(8'h07), .OFS_BASE(`LDIO_ECP_OFS)) u_ecp (
    .base(base_r[3]), .active(on_vec[3]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_ecp), .ofs(ofs_ecp));

  // Serial ports: eight registers each
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFF8), .ALIGN(3), .SPAN(3),
                .OFS_MASK(8'hFF), .OFS_BASE(12'h000)) u_sp1 (
    .base(base_r[4]), .active(on_vec[4]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_vec[4]), .ofs(ofs_sp1));

  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFF8), .ALIGN(3), .SPAN(3),
                .OFS_MASK(8'hFF), .OFS_BASE(12'h000)) u_sp2 (
    .base(base_r[5]), .active(on_vec[5]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_vec[5]), .ofs(ofs_sp2));

  // Game port: any byte, single register
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFFF), .ALIGN(0), .SPAN(0),
                .OFS_MASK(8'h01), .OFS_BASE(12'h000)) u_game (
    .base(base_r[9]), .active(on_vec[9]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_vec[9]), .ofs(ofs_game));

  // Runtime block: 128-byte window
  ldio_window #(.MIN_BASE(12'h000), .MAX_BASE(12'hF7F), .ALIGN(7), .SPAN(7),
                .OFS_MASK(8'hFF), .OFS_BASE(12'h000)) u_rt (
    .base(base_r[10]), .active(on_vec[10]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_vec[10]), .ofs(ofs_rt));

  // MIDI port: two registers on 2-byte alignment
  ldio_window #(.MIN_BASE(12'h100), .MAX_BASE(12'hFFE), .ALIGN(1), .SPAN(1),
                .OFS_MASK(8'h03), .OFS_BASE(12'h000)) u_mpu (
    .base(base_r[11]), .active(on_vec[11]), .qual16(qual16), .addr(host_req.addr),
    .hit(hit_vec[11]), .ofs(ofs_mpu));

  // Keyboard is fixed and ignores its base registers
  assign hit_kbd = on_vec[7] && (!qual16 || host_req.addr[15:12] == 4'h0)
                   && (host_req.addr[11:0] == `LDIO_KBD_DATA
                       || host_req.addr[11:0] == `LDIO_KBD_CMD);
  assign hit_vec[7] = hit_kbd;
  assign hit_vec[3] = hit_pp || hit_epp || hit_ecp;
  assign hit_vec[1] = 1'b0;
  assign hit_vec[2] = 1'b0;
  assign hit_vec[6] = 1'b0;
  assign hit_vec[8] = 1'b0;

  // Lowest device number wins; config port shadows all devices
  always_comb begin
    sel_nxt = 12'h000;
    ofs_nxt = 12'h000;
    if ((host_req.rd || host_req.wr) && !idx_hit && !dat_hit) begin
      for (int i = NUM_LDN - 1; i >= 0; i--) begin
        if (hit_vec[i]) begin
          sel_nxt    = 12'h000;
          sel_nxt[i] = 1'b1;
        end
      end
    end
    unique case (1'b1)
      sel_nxt[0]:  ofs_nxt = ofs_fdc;
      sel_nxt[3]:  ofs_nxt = hit_ecp ? ofs_ecp : (hit_epp ? ofs_epp : ofs_pp);
      sel_nxt[4]:  ofs_nxt = ofs_sp1;
      sel_nxt[5]:  ofs_nxt = ofs_sp2;
      sel_nxt[7]:  ofs_nxt = host_req.addr[11:0] - `LDIO_KBD_DATA;
      sel_nxt[9]:  ofs_nxt = ofs_game;
      sel_nxt[10]: ofs_nxt = ofs_rt;
      sel_nxt[11]: ofs_nxt = ofs_mpu;
      default:     ofs_nxt = 12'h000;
    endcase
  end

  // Registered device select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_sel_r <= '0;
    end else begin
      dev_sel_r.sel   <= sel_nxt;
      dev_sel_r.ofs   <= ofs_nxt;
      dev_sel_r.rd    <= host_req.rd && (sel_nxt != 12'h000);
      dev_sel_r.wr    <= host_req.wr && (sel_nxt != 12'h000);
      dev_sel_r.wdata <= host_req.wdata;
    end
  end

  // Interrupt routing by each device's select nibble
  always_comb begin
    irq_nxt   = 16'h0000;
    smi_share = 1'b0;
    for (int i = 0; i < NUM_LDN; i++) begin
      if (on_vec[i] && irq_r[i] != 4'h0) begin
        if (i == 3 && pp_ecp_epp_mode)
          irq_nxt[irq_r[i]] = irq_nxt[irq_r[i]] | ~dev_irq_req[i];
        else
          irq_nxt[irq_r[i]] = irq_nxt[irq_r[i]] | dev_irq_req[i];
        if (irq_r[i] == `LDIO_SMI_IRQ && dev_irq_req[i])
          smi_share = 1'b1;
      end
    end
    irq_nxt[0] = 1'b0;
  end

  // Interrupt lines and active-low system management output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_lines_r <= 16'h0000;
      smi_n_r     <= 1'b1;
    end else begin
      irq_lines_r <= irq_nxt;
      smi_n_r     <= ~(smi_req || smi_share);
    end
  end

  // Device power status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_on <= 12'h000;
    end else begin
      dev_on <= on_vec;
    end
  end

  // Config port address status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_port_addr <= `LDIO_CPORT_STRAP0;
    end else begin
      cfg_port_addr <= cport_r;
    end
  end

  assign dev_sel        = dev_sel_r;
  assign cfg_rdata      = cfg_rdata_r;
  assign cfg_rvalid     = cfg_rvalid_r;
  assign irq_lines      = irq_lines_r;
  assign sys_mgmt_irq_n = smi_n_r;

endmodule

`default_nettype wire

// ### testbench/ldio_monitor.sv
// Purpose: Port-level checks of the logical device I/O decode block
// Assumes: Sees only the ports of ldio_decode; one clock domain
// Notes:   Bound to every ldio_decode instance after the module
`default_nettype none

module ldio_monitor #(
  parameter int NUM_LDN = 12
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire ldio_pkg::ldio_host_req_s host_req,
  input wire logic                     config_port_strap,
  input wire logic [11:0]              dev_irq_req,
  input wire logic                     pp_ecp_epp_mode,
  input wire logic                     smi_req,
  input wire ldio_pkg::ldio_dev_sel_s  dev_sel,
  input wire logic [7:0]               cfg_rdata,
  input wire logic                     cfg_rvalid,
  input wire logic [15:0]              irq_lines,
  input wire logic                     sys_mgmt_irq_n,
  input wire logic [15:0]              cfg_port_addr,
  input wire logic [11:0]              dev_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Host read of the index or data port
  sequence cfg_read_s;
    host_req.rd && (host_req.addr == cfg_port_addr ||
      host_req.addr == cfg_port_addr + 16'h0001);
  endsequence
  // Host cycle at a fixed keyboard address while the keyboard is on
  sequence kbd_cyc_s(logic [15:0] a);
    (host_req.rd || host_req.wr) && host_req.addr == a && dev_on[7];
  endsequence
  // First edge after reset release with the strap high
  sequence strap_hi_s;
    $fell(rst) && config_port_strap;
  endsequence
  // Keyboard address must select the keyboard with the given offset
  property kbd_p(logic [15:0] a, logic [11:0] o);
    kbd_cyc_s(a) |=> dev_sel.sel[7] && dev_sel.ofs == o;
  endproperty

  cfg_answer_a: assert property (cfg_read_s |=> cfg_rvalid)
    else $error("config read gave no answer next cycle");
  rvalid_cause_a: assert property (cfg_rvalid |-> $past(host_req.rd))
    else $error("read answer without a read");
  sel_onehot_a: assert property ($onehot0(dev_sel.sel))
    else $error("more than one device selected");
  sel_cause_a: assert property (dev_sel.sel != 12'h000 |->
    (dev_on & dev_sel.sel) != 12'h000 && dev_sel.rd == $past(host_req.rd))
    else $error("select for an off device or without a cycle");
  floppy_skip_a: assert property (dev_sel.sel[0] |-> dev_sel.ofs != 12'h006)
    else $error("floppy offset six selected");
  kbd_data_a: assert property (kbd_p(16'h0060, 12'h000))
    else $error("keyboard data address not selected");
  kbd_cmd_a: assert property (kbd_p(16'h0064, 12'h004))
    else $error("keyboard command address not selected");
  irq_zero_a: assert property (irq_lines[0] == 1'b0)
    else $error("interrupt line zero driven");
  smi_low_a: assert property (smi_req |=> !sys_mgmt_irq_n)
    else $error("management interrupt not driven low");
  strap_port_a: assert property (strap_hi_s |-> ##[1:5] cfg_port_addr == 16'h004E)
    else $error("strap high did not move the config port");
endmodule

bind ldio_decode ldio_monitor #(.NUM_LDN(NUM_LDN)) mon (
  .clk(clk), .rst(rst), .host_req(host_req), .config_port_strap(config_port_strap),
  .dev_irq_req(dev_irq_req), .pp_ecp_epp_mode(pp_ecp_epp_mode), .smi_req(smi_req),
  .dev_sel(dev_sel), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .irq_lines(irq_lines), .sys_mgmt_irq_n(sys_mgmt_irq_n),
  .cfg_port_addr(cfg_port_addr), .dev_on(dev_on));

`default_nettype wire

// ### testbench/ldio_host_model.sv
// Purpose: Host model issuing single I/O cycles to the decode block
// Assumes: Strobe lasts one clock; read data lands one clock later
// Notes:   Released bus shows inverted address and data
`default_nettype none

module ldio_host_model (
  input  wire logic                     clk,
  input  wire logic [7:0]               cfg_rdata,
  output var  ldio_pkg::ldio_host_req_s host_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial host_req = '0;

  // One strobe, then release, then pick up the read answer
  task automatic cyc(input logic r, input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    host_req <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clk);
    host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = cfg_rdata;
  endtask
endmodule

`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the logical device I/O decode block
// Assumes: Host cycles come from the host model at 40 MHz
// Notes:   Rows pack read flag, address, data and expected select
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  rd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [11:0] sel;
  } ldio_row_s;

  logic                     clk;
  logic                     rst;
  logic                     config_port_strap;
  logic [11:0]              dev_irq_req;
  logic                     pp_ecp_epp_mode;
  logic                     smi_req;
  ldio_pkg::ldio_host_req_s host_req;
  ldio_pkg::ldio_dev_sel_s  dev_sel;
  logic [7:0]               cfg_rdata;
  logic                     cfg_rvalid;
  logic [15:0]              irq_lines;
  logic                     sys_mgmt_irq_n;
  logic [15:0]              cfg_port_addr;
  logic [11:0]              dev_on;
  logic [7:0]               q;
  logic [15:0]              port;
  int                       num_errors;
  int                       comparisons;
  ldio_row_s                rows [$] = '{
    40'h0002E07000, 40'h0002F00000, 40'h0002E70000, 40'h1002F06000, 40'h0002E74000,
    40'h1002F02000, 40'h0002E07000, 40'h0002F03000, 40'h0002E74000, 40'h1002F04000,
    40'h0002E70000, 40'h1002F00000, 40'h0002E60000, 40'h0002F03000, 40'h0002E61000,
    40'h0002F7C000, 40'h0002E30000, 40'h0002F01000, 40'h1037D00008, 40'h1037F00000,
    40'h1077E00008, 40'h0002E07000, 40'h0002F07000, 40'h0002E30000, 40'h0002F01000,
    40'h1006400080, 40'h1006000080, 40'h0002E07000, 40'h0002F09000, 40'h0002E60000,
    40'h0002F02000, 40'h0002E61000, 40'h0002F01000, 40'h0002E23000, 40'h0002F02000,
    40'h0002E30000, 40'h1002F01000, 40'h1020100200, 40'h1020200000, 40'h0002E07000,
    40'h0002F00000, 40'h0002E60000, 40'h0002F03000, 40'h0002E61000, 40'h0002FF0000,
    40'h0002E30000, 40'h0002F01000, 40'h103F200001, 40'h103F600000, 40'h103F700001,
    40'h113F200001, 40'h0002E24000, 40'h0002F40000, 40'h113F200000, 40'h103F500001,
    40'h0002E60000, 40'h0002F00000, 40'h0002E61000, 40'h0002F80000, 40'h1008200000,
    40'h0002E22000, 40'h0002F00000, 40'h1006000000, 40'h0002E30000, 40'h1002F00000};

  ldio_decode #(.NUM_LDN(12)) uut (
    .clk(clk), .rst(rst), .host_req(host_req), .config_port_strap(config_port_strap),
    .dev_irq_req(dev_irq_req), .pp_ecp_epp_mode(pp_ecp_epp_mode), .smi_req(smi_req),
    .dev_sel(dev_sel), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .irq_lines(irq_lines), .sys_mgmt_irq_n(sys_mgmt_irq_n),
    .cfg_port_addr(cfg_port_addr), .dev_on(dev_on));
  ldio_host_model host (.clk(clk), .cfg_rdata(cfg_rdata), .host_req(host_req));

  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Index write then data write through the current port
  task automatic set_reg(input logic [7:0] ix, input logic [7:0] d);
    host.cyc(1'b0, 1'b1, port, ix, q);
    host.cyc(1'b0, 1'b1, port + 16'h0001, d, q);
  endtask

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(5000 * 25);
    num_errors++;
    complete_run();
  end

  // Main sequence: reset, table, then hand-written cases
  initial begin
    num_errors = 0;
    comparisons = 0;
    {rst, config_port_strap, dev_irq_req, pp_ecp_epp_mode, smi_req} = 16'h8000;
    repeat (12) @(posedge clk);
    #1;
    `CHK(sys_mgmt_irq_n, 1'b1)
    @(posedge clk) rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK(cfg_port_addr, 16'h002E)
    foreach (rows[i]) begin
      host.cyc(rows[i].rd[0], !rows[i].rd[0], rows[i].addr, rows[i].data, q);
      `CHK(dev_sel.sel, rows[i].sel)
      if (rows[i].rd[0] && rows[i].addr == 16'h002F)
        `CHK(q, rows[i].data)
    end
    // Relocation: valid even word moves the port, odd word is refused
    port = 16'h002E;
    set_reg(8'h26, 8'h00);
    set_reg(8'h27, 8'h01);
    @(posedge clk);
    #1;
    `CHK(cfg_port_addr, 16'h0100)
    port = 16'h0100;
    set_reg(8'h26, 8'h03);
    @(posedge clk);
    #1;
    `CHK(cfg_port_addr, 16'h0100)
    // Game port interrupt on line 15, then on the shared line 2
    set_reg(8'h07, 8'h09);
    set_reg(8'h70, 8'h0F);
    @(posedge clk) dev_irq_req <= 12'h200;
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq_lines, 16'h8000)
    set_reg(8'h70, 8'h02);
    @(posedge clk);
    #1;
    `CHK(irq_lines, 16'h0004)
    `CHK(sys_mgmt_irq_n, 1'b0)
    @(posedge clk) dev_irq_req <= 12'h000;
    repeat (2) @(posedge clk);
    #1;
    `CHK(sys_mgmt_irq_n, 1'b1)
    @(posedge clk) smi_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(sys_mgmt_irq_n, 1'b0)
    // Parallel port in ECP/EPP mode idles its line high
    set_reg(8'h07, 8'h03);
    set_reg(8'h30, 8'h01);
    set_reg(8'h70, 8'h05);
    @(posedge clk) pp_ecp_epp_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq_lines, 16'h0020)
    // Second reset with the strap high
    @(posedge clk) {rst, config_port_strap, smi_req} <= 3'b110;
    repeat (12) @(posedge clk);
    #1;
    `CHK(dev_on, 12'h000)
    @(posedge clk) rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK(cfg_port_addr, 16'h004E)
    port = 16'h004E;
    host.cyc(1'b0, 1'b1, port, 8'h70, q);
    host.cyc(1'b1, 1'b0, port + 16'h0001, 8'h00, q);
    `CHK(q, 8'h06)
    complete_run();
  end
endmodule

`default_nettype wire
